// >>> design/adc_serial_output_framer.sv
`timescale 1ns/1ps
// Summary of operation
// - Two lanes send 8, 7 or 6 bits each per sample.
// - One lane sends 16, 14 or 12 bits per sample.
// - Data and frame change half a bit away from the data clock edge.
// - Each sample leaves six encode cycles after it was taken.
// - Two-lane 14-bit mode: frame marker toggles once per word.
// - Two pad bits follow the result in 16- and 14-bit modes, zero unless overranged.
// - Conversion starts on the rising encode edge.
// - One-lane mode drives only lane A; lane B disabled.
// - Config bits shift in on SCK rising edge while chip select low.
// - Readback drives open-drain SDO, host samples on SCK fall.
module adc_serial_output_framer
  import adc_framer_pkg::*;
(
  input  wire logic                   clk_sys,
  input  wire logic                   sys_rst,
  input  wire logic                   sample_clock_in,
  input  wire logic [SAMPLE_BITS-1:0] ch1_result,
  input  wire logic                   ch1_over,
  input  wire logic [SAMPLE_BITS-1:0] ch2_result,
  input  wire logic                   ch2_over,
  output logic                        sample_ready,
  output logic                        sample_dropped,
  input  wire logic                   cs_n,
  input  wire logic                   sck,
  input  wire logic                   sdi,
  output logic                        sdo_out,
  output logic                        sdo_oe,
  input  wire logic                   ser_clk,
  output logic                        serial_bit_clock_out,
  output logic                        word_frame_marker,
  output logic                        ch1_lane_a,
  output logic                        ch1_lane_b,
  output logic                        ch2_lane_a,
  output logic                        ch2_lane_b,
  output logic                        lane_b_en
);

  typedef enum logic [1:0] {
    LINK_IDLE  = 2'b01,
    LINK_SHIFT = 2'b10
  } link_state_t;

  // Link-side mode after reset, taken from the register's reset value
  localparam logic [2:0] MODE_LINK_RESET = {MODE_RESET[MODE_WIDTH_LSB +: 2],
                                            MODE_RESET[MODE_ONE_LANE_BIT]};

  // System clock domain
  logic [7:0]            mode_reg;
  logic [2:0]            enc_sync_reg;
  logic [CHAN_BITS-1:0]  pipe1_reg [LATENCY_CYCLES];
  logic [CHAN_BITS-1:0]  pipe2_reg [LATENCY_CYCLES];
  logic [LATENCY_CYCLES-1:0] pipe_vld_reg;
  logic [FIFO_WIDTH-1:0] fifo_out;
  logic                  fifo_out_valid;
  logic [FIFO_WIDTH-1:0] hold_reg;
  logic                  busy_reg;
  logic                  req_tgl_reg;
  logic                  ack_meta_reg;
  logic                  ack_sync_reg;
  wire                   enc_rise;
  wire                   push_sample;
  wire                   take_word;

  // Link clock domain
  logic                  rst_meta_reg;
  logic                  link_rst;
  logic [2:0]            mode_meta_reg;
  logic [2:0]            mode_sync_reg;
  logic [2:0]            mode_prev_reg;
  logic [2:0]            mode_link_reg;
  logic                  req_meta_reg;
  logic                  req_sync_reg;
  logic                  ack_tgl_reg;
  logic [FIFO_WIDTH-1:0] buf_reg;
  logic                  have_word_reg;
  link_state_t           state_reg;
  logic [WORD_BITS-1:0]  sh1_reg;
  logic [WORD_BITS-1:0]  sh2_reg;
  logic [CNT_BITS-1:0]   cnt_reg;
  logic                  dco_reg;
  wire                   one_lane;
  wire [1:0]             width;
  wire [CNT_BITS-1:0]    lane_len;
  wire [CNT_BITS-1:0]    half_len;
  wire                   frame_toggles;
  wire                   word_end;
  wire                   load_word;
  wire [CNT_BITS-1:0]    cnt_next;
  wire                   frame_first_half;
  wire [WORD_BITS-1:0]   fmt1;
  wire [WORD_BITS-1:0]   fmt2;
  wire [WORD_BITS-1:0]   src1;
  wire [WORD_BITS-1:0]   src2;
  wire [WORD_BITS-1:0]   nxt1;
  wire [WORD_BITS-1:0]   nxt2;

  mode_spi_slave i_mode_spi_slave (
    .clk_sys  (clk_sys),
    .sys_rst  (sys_rst),
    .cs_n     (cs_n),
    .sck      (sck),
    .sdi      (sdi),
    .sdo_out  (sdo_out),
    .sdo_oe   (sdo_oe),
    .mode_reg (mode_reg)
  );

  // Encode pin is asynchronous: two flops, then edge detect
  always_ff @(posedge clk_sys) begin
    enc_sync_reg <= {enc_sync_reg[1:0], sample_clock_in};
  end
  assign enc_rise = enc_sync_reg[1] & ~enc_sync_reg[2];

  // Latency pipe advances once per encode edge
  always_ff @(posedge clk_sys) begin
    if (enc_rise) begin
      pipe1_reg[0] <= {ch1_over, ch1_result};
      pipe2_reg[0] <= {ch2_over, ch2_result};
      for (int i = 1; i < LATENCY_CYCLES; i++) begin
        pipe1_reg[i] <= pipe1_reg[i-1];
        pipe2_reg[i] <= pipe2_reg[i-1];
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      pipe_vld_reg   <= '0;
      sample_dropped <= 1'b0;
    end else begin
      if (enc_rise) begin
        pipe_vld_reg <= {pipe_vld_reg[LATENCY_CYCLES-2:0], 1'b1};
      end
      // Converter cannot stall: a full FIFO loses the word
      sample_dropped <= push_sample & ~sample_ready;
    end
  end

  assign push_sample = enc_rise & pipe_vld_reg[LATENCY_CYCLES-1];

  // Cushion between the encode rate and a link that drains in bursts
  sample_fifo #(
    .WIDTH (FIFO_WIDTH),
    .DEPTH (FIFO_DEPTH)
  ) i_sample_fifo (
    .clk_sys   (clk_sys),
    .sys_rst   (sys_rst),
    .in_data   ({pipe1_reg[LATENCY_CYCLES-1], pipe2_reg[LATENCY_CYCLES-1]}),
    .in_valid  (push_sample),
    .in_ready  (sample_ready),
    .out_data  (fifo_out),
    .out_valid (fifo_out_valid),
    .out_ready (take_word)
  );

  // Word handshake toward the link: hold stays still while pending
  assign take_word = fifo_out_valid & ~busy_reg;

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      hold_reg     <= '0;
      busy_reg     <= 1'b0;
      req_tgl_reg  <= 1'b0;
      ack_meta_reg <= 1'b0;
      ack_sync_reg <= 1'b0;
    end else begin
      ack_meta_reg <= ack_tgl_reg;
      ack_sync_reg <= ack_meta_reg;
      if (take_word) begin
        hold_reg    <= fifo_out;
        req_tgl_reg <= ~req_tgl_reg;
        busy_reg    <= 1'b1;
      end else if (busy_reg && ack_sync_reg == req_tgl_reg) begin
        busy_reg <= 1'b0;
      end
    end
  end

  // Link domain: reset and quasi-static mode pass two flops
  always_ff @(posedge ser_clk) begin
    rst_meta_reg  <= sys_rst;
    link_rst      <= rst_meta_reg;
    mode_meta_reg <= {mode_reg[MODE_WIDTH_LSB +: 2],
                      mode_reg[MODE_ONE_LANE_BIT]};
    mode_sync_reg <= mode_meta_reg;
    req_meta_reg  <= req_tgl_reg;
    req_sync_reg  <= req_meta_reg;
  end

  // Mode bits may settle on different link edges; take them only once
  // two samples in a row agree, so the link never sees a torn mode
  always_ff @(posedge ser_clk) begin
    if (link_rst) begin
      mode_prev_reg <= MODE_LINK_RESET;
      mode_link_reg <= MODE_LINK_RESET;
    end else begin
      mode_prev_reg <= mode_sync_reg;
      if (mode_sync_reg == mode_prev_reg) begin
        mode_link_reg <= mode_prev_reg;
      end
    end
  end

  // Mode changes should be made while no samples flow
  assign one_lane      = mode_link_reg[0];
  assign width         = mode_link_reg[2:1];
  assign lane_len      = bits_per_lane(width, one_lane);
  assign half_len      = lane_len >> 1;
  assign frame_toggles = ~one_lane & (width == WIDTH_14);
  assign word_end      = (state_reg == LINK_IDLE) || (cnt_reg == '0);
  assign load_word     = word_end & have_word_reg;
  assign cnt_next      = load_word ? lane_len - 1'b1 : cnt_reg - 1'b1;
  // High over the first half of the word's bits
  assign frame_first_half = (cnt_next > lane_len - 1'b1 - half_len);

  assign fmt1 = format_word(buf_reg[FIFO_WIDTH-2 -: SAMPLE_BITS],
                            buf_reg[FIFO_WIDTH-1], width);
  assign fmt2 = format_word(buf_reg[SAMPLE_BITS-1:0],
                            buf_reg[CHAN_BITS-1], width);
  assign src1 = load_word ? fmt1 : sh1_reg;
  assign src2 = load_word ? fmt2 : sh2_reg;
  // Lane A carries the even bits from the top, lane B the odd ones
  assign nxt1 = one_lane ? (src1 << 1) : (src1 << 2);
  assign nxt2 = one_lane ? (src2 << 1) : (src2 << 2);

  // One word waits here so that words leave back to back
  always_ff @(posedge ser_clk) begin
    if (link_rst) begin
      ack_tgl_reg   <= 1'b0;
      buf_reg       <= '0;
      have_word_reg <= 1'b0;
    end else begin
      if (req_sync_reg != ack_tgl_reg && (!have_word_reg || load_word)) begin
        buf_reg       <= hold_reg;
        have_word_reg <= 1'b1;
        ack_tgl_reg   <= req_sync_reg;
      end else if (load_word) begin
        have_word_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge ser_clk) begin
    if (link_rst) begin
      state_reg         <= LINK_IDLE;
      sh1_reg           <= '0;
      sh2_reg           <= '0;
      cnt_reg           <= '0;
      word_frame_marker <= 1'b0;
      ch1_lane_a        <= 1'b0;
      ch1_lane_b        <= 1'b0;
      ch2_lane_a        <= 1'b0;
      ch2_lane_b        <= 1'b0;
    end else begin
      case (state_reg)
        LINK_IDLE, LINK_SHIFT: begin
          if (word_end && !have_word_reg) begin
            state_reg  <= LINK_IDLE;
            ch1_lane_a <= 1'b0;
            ch1_lane_b <= 1'b0;
            ch2_lane_a <= 1'b0;
            ch2_lane_b <= 1'b0;
          end else begin
            state_reg  <= LINK_SHIFT;
            ch1_lane_a <= src1[WORD_BITS-1];
            ch2_lane_a <= src2[WORD_BITS-1];
            ch1_lane_b <= ~one_lane & src1[WORD_BITS-2];
            ch2_lane_b <= ~one_lane & src2[WORD_BITS-2];
            sh1_reg    <= nxt1;
            sh2_reg    <= nxt2;
            cnt_reg    <= cnt_next;
            if (frame_toggles) begin
              if (load_word) begin
                word_frame_marker <= ~word_frame_marker;
              end
            end else begin
              word_frame_marker <= frame_first_half;
            end
          end
        end
        default: begin
          state_reg <= LINK_IDLE;
        end
      endcase
    end
  end

  // Bit clock turns on the opposite edge, so it lands mid-bit
  always_ff @(negedge ser_clk) begin
    if (link_rst) begin
      dco_reg <= 1'b0;
    end else begin
      dco_reg <= ~dco_reg;
    end
  end

  assign serial_bit_clock_out = dco_reg;
  assign lane_b_en            = ~one_lane;

endmodule : adc_serial_output_framer

// >>> design/mode_spi_slave.sv
`timescale 1ns/1ps
module mode_spi_slave
  import adc_framer_pkg::*;
(
  input  wire logic       clk_sys,
  input  wire logic       sys_rst,
  input  wire logic       cs_n,
  input  wire logic       sck,
  input  wire logic       sdi,
  output logic            sdo_out,
  output logic            sdo_oe,
  output logic [7:0]      mode_reg
);

  logic [2:0]              meta_reg;
  logic [2:0]              sync_reg;
  logic                    sck_prev_reg;
  logic [SPI_CNT_BITS-1:0] cnt_reg;
  logic [SPI_FRAME_BITS-2:0] shift_reg;
  logic                    read_reg;
  logic [7:0]              rdata_reg;
  logic                    sdo_bit_reg;
  wire                     cs_act;
  wire                     sck_rise;
  wire                     sck_fall;
  wire                     cmd_done;
  wire                     frame_done;

  // Two flops on every pin before any logic looks at it
  always_ff @(posedge clk_sys) begin
    meta_reg <= {cs_n, sck, sdi};
    sync_reg <= meta_reg;
  end

  assign cs_act     = ~sync_reg[2];
  assign sck_rise   = cs_act & sync_reg[1] & ~sck_prev_reg;
  assign sck_fall   = cs_act & ~sync_reg[1] & sck_prev_reg;
  assign cmd_done   = sck_rise & (cnt_reg == SPI_CNT_BITS'(SPI_CMD_BITS-1));
  assign frame_done = sck_rise & (cnt_reg == SPI_CNT_BITS'(SPI_FRAME_BITS-1));
  assign sdo_out    = 1'b0;
  // Open drain: pull low only for a zero bit
  assign sdo_oe     = cs_act & read_reg & ~sdo_bit_reg;

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      sck_prev_reg <= 1'b0;
      cnt_reg      <= '0;
      shift_reg    <= '0;
      read_reg     <= 1'b0;
      rdata_reg    <= '0;
      sdo_bit_reg  <= 1'b1;
      mode_reg     <= MODE_RESET;
    end else begin
      sck_prev_reg <= sync_reg[1];
      if (!cs_act) begin
        cnt_reg     <= '0;
        read_reg    <= 1'b0;
        sdo_bit_reg <= 1'b1;
      end else begin
        if (sck_rise) begin
          shift_reg <= {shift_reg[SPI_FRAME_BITS-3:0], sync_reg[0]};
          cnt_reg   <= cnt_reg + 1'b1;
        end
        if (cmd_done) begin
          read_reg  <= shift_reg[SPI_CMD_BITS-2];
          rdata_reg <= ({shift_reg[SPI_CMD_BITS-3:0], sync_reg[0]}
                        == MODE_ADDR) ? mode_reg : 8'h00;
        end
        // Readback bits change on the falling edge
        if (sck_fall && read_reg) begin
          sdo_bit_reg <= rdata_reg[7];
          rdata_reg   <= {rdata_reg[6:0], 1'b0};
        end
        if (frame_done && !shift_reg[SPI_FRAME_BITS-2] &&
            shift_reg[SPI_FRAME_BITS-3:SPI_CMD_BITS-1] == MODE_ADDR) begin
          mode_reg <= {shift_reg[6:0], sync_reg[0]};
        end
      end
    end
  end

endmodule : mode_spi_slave

// >>> design/sample_fifo.sv
`timescale 1ns/1ps
module sample_fifo #(
  parameter int WIDTH = 26,
  parameter int DEPTH = 4
) (
  input  wire logic             clk_sys,
  input  wire logic             sys_rst,
  input  wire logic [WIDTH-1:0] in_data,
  input  wire logic             in_valid,
  output logic                  in_ready,
  output logic      [WIDTH-1:0] out_data,
  output logic                  out_valid,
  input  wire logic             out_ready
);

  localparam int PTR_BITS = $clog2(DEPTH);

  logic [WIDTH-1:0]    mem [DEPTH];
  logic [PTR_BITS-1:0] wr_ptr_reg;
  logic [PTR_BITS-1:0] rd_ptr_reg;
  logic [PTR_BITS:0]   count_reg;
  wire                 push;
  wire                 pop;

  assign in_ready  = (count_reg != (PTR_BITS+1)'(DEPTH));
  assign out_valid = (count_reg != '0);
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;
  assign out_data  = mem[rd_ptr_reg];

  always_ff @(posedge clk_sys) begin
    if (push) begin
      mem[wr_ptr_reg] <= in_data;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg  <= '0;
    end else begin
      if (push) begin
        wr_ptr_reg <= wr_ptr_reg + 1'b1;
      end
      if (pop) begin
        rd_ptr_reg <= rd_ptr_reg + 1'b1;
      end
      count_reg <= count_reg + (PTR_BITS+1)'(push) - (PTR_BITS+1)'(pop);
    end
  end

endmodule : sample_fifo

// >>> shared/adc_framer_pkg.sv
package adc_framer_pkg;

  localparam int SAMPLE_BITS    = 12;
  localparam int WORD_BITS      = 16;
  localparam int LATENCY_CYCLES = 6;
  localparam int FIFO_DEPTH     = 4;
  localparam int CNT_BITS       = 5;
  // One channel in the FIFO: overrange flag on top of the result
  localparam int CHAN_BITS      = SAMPLE_BITS + 1;
  localparam int FIFO_WIDTH     = 2 * CHAN_BITS;

  // Serialization width codes
  localparam logic [1:0] WIDTH_16 = 2'h0;
  localparam logic [1:0] WIDTH_14 = 2'h1;
  localparam logic [1:0] WIDTH_12 = 2'h2;

  localparam logic [CNT_BITS-1:0] LEN_16 = 5'h10;
  localparam logic [CNT_BITS-1:0] LEN_14 = 5'h0e;
  localparam logic [CNT_BITS-1:0] LEN_12 = 5'h0c;

  // Configuration port framing: R/W flag, 7-bit address, 8-bit data
  localparam int SPI_CMD_BITS   = 8;
  localparam int SPI_FRAME_BITS = 16;
  localparam int SPI_CNT_BITS   = 5;
  localparam logic [6:0] MODE_ADDR  = 7'h03;
  localparam logic [7:0] MODE_RESET = 8'h00;
  localparam int MODE_ONE_LANE_BIT  = 0;
  localparam int MODE_WIDTH_LSB     = 1;

  // Bits sent on each lane for one sample word
  function automatic logic [CNT_BITS-1:0] bits_per_lane(
    input logic [1:0] width,
    input logic       one_lane
  );
    logic [CNT_BITS-1:0] len;
    len = (width == WIDTH_14) ? LEN_14 :
          (width == WIDTH_12) ? LEN_12 : LEN_16;
    bits_per_lane = one_lane ? len : (len >> 1);
  endfunction : bits_per_lane

  // Left-aligned word: result, two pad bits, zero fill
  function automatic logic [WORD_BITS-1:0] format_word(
    input logic [SAMPLE_BITS-1:0] result,
    input logic                   over,
    input logic [1:0]             width
  );
    logic pad;
    pad = (width != WIDTH_12) & over;
    format_word = {result, pad, pad, 2'h0};
  endfunction : format_word

endpackage : adc_framer_pkg

// >>> test/adc_serial_output_framer_monitor.sv
`timescale 1ns/1ps
module adc_serial_output_framer_monitor (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic sample_ready,
  input wire logic sample_dropped,
  input wire logic cs_n,
  input wire logic sdo_out,
  input wire logic sdo_oe,
  input wire logic ser_clk,
  input wire logic serial_bit_clock_out,
  input wire logic word_frame_marker,
  input wire logic ch1_lane_a,
  input wire logic ch1_lane_b,
  input wire logic ch2_lane_b,
  input wire logic lane_b_en
);
  property p_rst_vals;
    @(posedge clk_sys) disable iff (sys_rst)
      $fell(sys_rst) |-> sample_ready && !sample_dropped && !sdo_oe;
  endproperty
  a_rst_vals: assert property (p_rst_vals)
    else $error("outputs not idle after reset");
  property p_sdo_start;
    @(posedge clk_sys) disable iff (sys_rst)
      $rose(sdo_oe) |-> !cs_n && !sdo_out;
  endproperty
  a_sdo_start: assert property (p_sdo_start)
    else $error("sdo driven without select");
  property p_sdo_release;
    @(posedge clk_sys) disable iff (sys_rst) cs_n [*4] |-> !sdo_oe;
  endproperty
  a_sdo_release: assert property (p_sdo_release)
    else $error("sdo held after deselect");
  property p_drop_full;
    @(posedge clk_sys) disable iff (sys_rst)
      sample_dropped |-> !$past(sample_ready);
  endproperty
  a_drop_full: assert property (p_drop_full)
    else $error("drop while buffer had room");
  property p_drop_pulse;
    @(posedge clk_sys) disable iff (sys_rst)
      sample_dropped |=> !sample_dropped;
  endproperty
  a_drop_pulse: assert property (p_drop_pulse)
    else $error("drop pulse too long");
  // Data and clock edges must never share a sampling window
  property p_mid_bit;
    @(posedge clk_sys) disable iff (sys_rst)
      $changed(ch1_lane_a) || $changed(word_frame_marker)
      |-> $stable(serial_bit_clock_out);
  endproperty
  a_mid_bit: assert property (p_mid_bit)
    else $error("data moved with data clock");
  property p_dco_run;
    @(posedge ser_clk) disable iff (sys_rst)
      $past(serial_bit_clock_out) != $past(serial_bit_clock_out, 2)
      |-> serial_bit_clock_out != $past(serial_bit_clock_out);
  endproperty
  a_dco_run: assert property (p_dco_run)
    else $error("data clock missed a bit");
  property p_lane_b_off;
    @(posedge ser_clk) disable iff (sys_rst)
      !lane_b_en |-> !ch1_lane_b && !ch2_lane_b;
  endproperty
  a_lane_b_off: assert property (p_lane_b_off)
    else $error("second lane active in one-lane mode");
  property p_frame_min;
    @(posedge ser_clk) disable iff (sys_rst)
      $rose(word_frame_marker) |-> word_frame_marker [*3];
  endproperty
  a_frame_min: assert property (p_frame_min)
    else $error("frame marker too short");
endmodule : adc_serial_output_framer_monitor

// >>> test/adc_serial_output_framer_test.sv
`timescale 1ns/1ps
module adc_serial_output_framer_test;
  import adc_framer_pkg::*;
  logic                   clk_sys;
  logic                   sys_rst;
  logic                   sample_clock_in;
  logic [SAMPLE_BITS-1:0] ch1_result;
  logic [SAMPLE_BITS-1:0] ch2_result;
  logic                   ch1_over;
  logic                   ch2_over;
  logic                   sample_ready;
  logic                   sample_dropped;
  logic                   cs_n;
  logic                   sck;
  logic                   sdi;
  logic                   sdo_out;
  logic                   sdo_oe;
  logic                   ser_clk;
  logic                   serial_bit_clock_out;
  logic                   word_frame_marker;
  logic                   ch1_lane_a;
  logic                   ch1_lane_b;
  logic                   ch2_lane_a;
  logic                   ch2_lane_b;
  logic                   lane_b_en;
  logic                   one_lane_m;
  logic [1:0]             width_m;
  logic [15:0]            rx_ch1;
  logic [15:0]            rx_ch2;
  logic [15:0]            got1[$];
  logic [15:0]            got2[$];
  int                     rx_count;
  int                     fails;
  int                     checks_done;
  int                     cycles;
  int                     drops;
  // Open drain with pull-up
  wire                    sdo_line = sdo_oe ? sdo_out : 1'b1;

  adc_serial_output_framer i_adc_serial_output_framer (
    .clk_sys, .sys_rst, .sample_clock_in, .ch1_result, .ch1_over,
    .ch2_result, .ch2_over, .sample_ready, .sample_dropped, .cs_n,
    .sck, .sdi, .sdo_out, .sdo_oe, .ser_clk, .serial_bit_clock_out,
    .word_frame_marker, .ch1_lane_a, .ch1_lane_b, .ch2_lane_a,
    .ch2_lane_b, .lane_b_en);
  lane_receiver_model i_lane_receiver_model (
    .rst(sys_rst), .one_lane(one_lane_m), .width(width_m),
    .serial_bit_clock_out, .word_frame_marker, .ch1_lane_a,
    .ch1_lane_b, .ch2_lane_a, .ch2_lane_b, .rx_ch1, .rx_ch2, .rx_count);

  initial clk_sys = 1'b0;
  always #5 clk_sys = ~clk_sys;
  initial begin
    ser_clk = 1'b0;
    #2.3;
    forever #80 ser_clk = ~ser_clk;
  end

  always @(rx_count) begin
    if (rx_count > 0) begin
      got1.push_back(rx_ch1);
      got2.push_back(rx_ch2);
    end
  end
  always @(posedge clk_sys) begin
    if (sample_dropped === 1'b1) drops++;
    cycles++;
    if (cycles == 60000) begin
      fails++;
      final_report();
    end
  end

  task automatic final_report;
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : final_report

  task automatic check(input string what, input logic [15:0] seen,
                       input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic tick(input int n);
    repeat (n) @(negedge clk_sys);
  endtask : tick

  // Link side needs several of its own edges, hence the long hold
  task automatic do_reset;
    sys_rst = 1'b1;
    tick(96);
    sys_rst = 1'b0;
    got1.delete();
    got2.delete();
    drops = 0;
  endtask : do_reset

  task automatic spi(input logic [15:0] frame, output logic [7:0] rd);
    cs_n = 1'b0;
    for (int i = 15; i >= 0; i--) begin
      sdi = frame[i];
      tick(15);
      sck = 1'b1;
      tick(15);
      if (i < 8) rd = {rd[6:0], sdo_line};
      sck = 1'b0;
    end
    tick(15);
    cs_n = 1'b1;
    tick(15);
  endtask : spi

  task automatic encode(input int n, input int period);
    for (int k = 0; k < n; k++) begin
      ch1_result = 12'h0a5 + 12'(k) * 12'h135;
      ch2_result = ~ch1_result;
      ch1_over = k[0];
      ch2_over = ~k[0];
      sample_clock_in = 1'b1;
      tick(period / 2);
      sample_clock_in = 1'b0;
      tick(period - period / 2);
    end
  endtask : encode

  function automatic logic [15:0] expect_word(input int k,
                                              input logic ch2);
    logic [11:0] r;
    logic        p;
    int          len;
    r = 12'h0a5 + 12'(k) * 12'h135;
    if (ch2) r = ~r;
    p = (k[0] ^ ch2) && width_m != 2'h2;
    len = width_m == 2'h1 ? 14 : width_m == 2'h2 ? 12 : 16;
    expect_word = {r, p, p, 2'h0} & ~(16'hffff >> len);
  endfunction : expect_word

  task automatic mode_case(input logic one, input logic [1:0] w);
    logic [7:0] rd;
    do_reset();
    one_lane_m = one;
    width_m = w;
    spi({1'b0, MODE_ADDR, 5'h00, w, one}, rd);
    spi({1'b1, MODE_ADDR, 8'h00}, rd);
    check("mode read", 16'(rd), {13'h0, w, one});
    spi({1'b1, 7'h7f, 8'h00}, rd);
    check("unmapped read", 16'(rd), 16'h0000);
    tick(10);
    check("lane b enable", 16'(lane_b_en), 16'(!one));
    encode(9, 300);
    tick(400);
    check("word count", 16'(got1.size()), 16'h0003);
    for (int j = 0; j < 3; j++) begin
      check("ch1 word", got1[j], expect_word(j, 1'b0));
      check("ch2 word", got2[j], expect_word(j, 1'b1));
    end
  endtask : mode_case

  task automatic fill_case;
    logic saw_full;
    do_reset();
    one_lane_m = 1'b0;
    width_m = 2'h0;
    saw_full = 1'b0;
    fork
      encode(24, 6);
      repeat (150) begin
        @(negedge clk_sys);
        if (sample_ready === 1'b0) saw_full = 1'b1;
      end
    join
    check("buffer full", 16'(saw_full), 16'h0001);
    check("drop seen", 16'(drops != 0), 16'h0001);
    tick(3000);
    check("buffer drained", 16'(sample_ready), 16'h0001);
    for (int j = 0; j < FIFO_DEPTH; j++) begin
      check("buffered word", got1[j], expect_word(j, 1'b0));
    end
  endtask : fill_case

  initial begin
    sys_rst = 1'b1;
    sample_clock_in = 1'b0;
    ch1_result = '0;
    ch2_result = '0;
    ch1_over = 1'b0;
    ch2_over = 1'b0;
    cs_n = 1'b1;
    sck = 1'b0;
    sdi = 1'b0;
    one_lane_m = 1'b0;
    width_m = 2'h0;
    for (int m = 0; m < 8; m++) begin
      mode_case(m >= 4, 2'(m % 4));
    end
    fill_case();
    final_report();
  end
endmodule : adc_serial_output_framer_test

bind adc_serial_output_framer adc_serial_output_framer_monitor
  i_adc_serial_output_framer_monitor (
    .clk_sys, .sys_rst, .sample_ready, .sample_dropped, .cs_n,
    .sdo_out, .sdo_oe, .ser_clk, .serial_bit_clock_out,
    .word_frame_marker, .ch1_lane_a, .ch1_lane_b, .ch2_lane_b,
    .lane_b_en);

// >>> test/lane_receiver_model.sv
`timescale 1ns/1ps
module lane_receiver_model (
  input  wire logic        rst,
  input  wire logic        one_lane,
  input  wire logic [1:0]  width,
  input  wire logic        serial_bit_clock_out,
  input  wire logic        word_frame_marker,
  input  wire logic        ch1_lane_a,
  input  wire logic        ch1_lane_b,
  input  wire logic        ch2_lane_a,
  input  wire logic        ch2_lane_b,
  output logic      [15:0] rx_ch1,
  output logic      [15:0] rx_ch2,
  output int               rx_count
);
  logic [15:0] sh1;
  logic [15:0] sh2;
  logic        prev_fr;
  logic        busy;
  logic        toggle_mode;
  int          len;
  int          cnt;
  assign toggle_mode = !one_lane && width == 2'h1;
  assign len = width == 2'h1 ? 14 : width == 2'h2 ? 12 : 16;
  // Every data clock edge lands mid-bit, so both are sample points
  always @(posedge serial_bit_clock_out or negedge serial_bit_clock_out
           or posedge rst) begin
    if (rst) begin
      busy = 1'b0;
      prev_fr = 1'b0;
      rx_count = 0;
    end else begin
      if (word_frame_marker != prev_fr &&
          (word_frame_marker || toggle_mode)) begin
        busy = 1'b1;
        cnt = 0;
      end
      prev_fr = word_frame_marker;
      if (busy) begin
        if (one_lane) begin
          sh1 = {sh1[14:0], ch1_lane_a};
          sh2 = {sh2[14:0], ch2_lane_a};
          cnt = cnt + 1;
        end else begin
          sh1 = {sh1[13:0], ch1_lane_a, ch1_lane_b};
          sh2 = {sh2[13:0], ch2_lane_a, ch2_lane_b};
          cnt = cnt + 2;
        end
        if (cnt == len) begin
          rx_ch1 = sh1 << (16 - len);
          rx_ch2 = sh2 << (16 - len);
          busy = 1'b0;
          rx_count = rx_count + 1;
        end
      end
    end
  end
endmodule : lane_receiver_model
